/* wrc_watchdog_reset.sv */
// watchdog timer, supply monitor control and reset-cause flags behind apb
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps

// What this block does
// R01: watchdog counts slow oscillator ticks, timeout 2^8 to 2^15 ticks
// R02: key 01010 enables watchdog, 10101 disables it
// R03: any other key resets device after delay and sets watchdog key flag
// R04: watchdog control reads 0x53 after power-on, watchdog enabled
// R05: select 000 gives 2^8, each step doubles, 111 gives 2^15
// R06: overflow while running resets device and sets timeout flag
// R07: overflow while halted sets timeout flag, clears only pc and sp
// R08: count cleared by bad key, clear instruction or halt
// R09: watchdog key flag set by hardware, cleared only by software zero
// R10: low supply resets and flags only if it outlasts qualify time
// R11: supply key 0x5a enables low supply reset, 0xa5 disables it
// R12: other supply key resets after delay, sets flag, restores 0x5a
// R13: genuine low supply reset keeps supply control register contents
// R14: low supply detection off while halted
// R15: supply control register holds 0x5a after power-on
// R16: bandgap enable bit 3 resets 0; bandgap on if bit or monitor
// R17: low supply flag set by real low supply, cleared by software only
// R18: supply key flag set by bad supply key, cleared by software only
// R19: cause bits 7..3 read zero; key flags zero at power-on
// R20: power-on reset clears pc and sets port data and direction high
// R21: halted overflow leaves timeout and power-down high; low supply keeps them
// R22: halt sets power-down, clears timeout and count; count runs if enabled
// R23: soft reset delay and qualify time count slow oscillator ticks
module wrc_watchdog_reset (
  input wire logic mclk,
  input wire logic rst_b,
  input wire wrc_pkg::wrc_apb_req_s apbReq,
  output wrc_pkg::wrc_apb_rsp_s apbRsp,
  input wire logic slowOscClock,
  input wire logic lowSupplyIn,
  input wire logic clearWatchdogInstr,
  input wire logic haltInstr,
  input wire logic wakeEvent,
  output logic deviceReset,
  output logic pcSpClear,
  output logic powerOnInit,
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic lowSupplyEnable,
  output logic bandgapPower,
  output logic halted
);

  // ************************************************************
  // helpers
  // ************************************************************
  localparam int WRC_MIN_DIV_LOG2_W = wrc_pkg::WRC_MIN_DIV_LOG2;

  // terminal count of the watchdog for a timeout select code
  function automatic logic [14:0] wrcLimit(input logic [2:0] sel);
    logic [15:0] full;
    full = 16'h0001 << (WRC_MIN_DIV_LOG2_W + {13'h0000, sel});
    wrcLimit = 15'(full - 16'h0001);
  endfunction

  // read mux of the register file
  function automatic logic [32:0] wrcRead(input logic [7:0] adr, input wrc_pkg::wrc_state_s s);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (adr)
      wrc_pkg::WRC_OFS_WDT_CTRL: r[7:0] = s.wdtCtrl;
      // upper cause bits read zero
      wrc_pkg::WRC_OFS_CAUSE: r[2:0] = s.cause;
      wrc_pkg::WRC_OFS_LV_CTRL: r[7:0] = s.lvCtrl;
      wrc_pkg::WRC_OFS_BANDGAP: r[wrc_pkg::WRC_BG_BIT] = s.bgEn;
      wrc_pkg::WRC_OFS_STATUS: r[1:0] = {s.pdFlag, s.toFlag};
      default: r[32] = 1'b1;
    endcase
    wrcRead = r;
  endfunction

  // key field holding neither the enable nor the disable code
  function automatic logic wrcKeyBad(input logic [4:0] k);
    wrcKeyBad = (k != wrc_pkg::WRC_KEY_ENABLE) && (k != wrc_pkg::WRC_KEY_DISABLE);
  endfunction

  // filtered level: follows the last stage once the last two agree
  function automatic logic wrcFilt(input logic [2:0] s, input logic prev);
    wrcFilt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  wrc_pkg::wrc_state_s st_ff;
  wrc_pkg::wrc_state_s nxt_st;

  logic [4:0] key;
  logic wdtOn;
  logic lvOn;
  logic isHalted;
  logic tick;
  logic lowNow;
  logic access;
  logic wrEn;
  logic keyBad;
  logic lvBad;
  logic wdtOverflow;
  logic softFireW;
  logic softFireL;
  logic lvFire;
  logic anyFullReset;
  logic [32:0] rd;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    // ************************************************************
    // key decode
    // ************************************************************
    key = st_ff.wdtCtrl[7:wrc_pkg::WRC_KEY_LSB];
    isHalted = (st_ff.pwr == wrc_pkg::WRC_HALTED);
    // R02: key decode
    wdtOn = (key == wrc_pkg::WRC_KEY_ENABLE);
    keyBad = wrcKeyBad(key);
    // R11: supply key decode
    lvOn = (st_ff.lvCtrl == wrc_pkg::WRC_LV_ENABLE);
    lvBad = !lvOn && (st_ff.lvCtrl != wrc_pkg::WRC_LV_DISABLE);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // three-stage synchronisers; change counts once stages 2 and 3 agree
    nxt_st.oscSync = {st_ff.oscSync[1:0], slowOscClock};
    nxt_st.lowSync = {st_ff.lowSync[1:0], lowSupplyIn};
    nxt_st.oscStable = wrcFilt(st_ff.oscSync, st_ff.oscStable);
    nxt_st.lowStable = wrcFilt(st_ff.lowSync, st_ff.lowStable);
    // R01: one tick per rising edge of the slow clock
    tick = (st_ff.oscSync[1] == st_ff.oscSync[2]) && st_ff.oscSync[2] && !st_ff.oscStable;
    lowNow = st_ff.lowStable;

    // ************************************************************
    // watchdog counter
    // ************************************************************
    // R05: limit follows timeout select
    wdtOverflow = wdtOn && tick && (st_ff.wdtCnt == wrcLimit(st_ff.wdtCtrl[2:0]));
    // R01: count only enabled ticks
    if (wdtOn && tick) begin
      nxt_st.wdtCnt = 15'(st_ff.wdtCnt + 15'h0001);
    end
    if (wdtOverflow) begin
      nxt_st.wdtCnt = 15'h0000;
    end

    // ************************************************************
    // keyed soft resets
    // ************************************************************
    // R03: bad key arms reset
    // R23: delay counted in slow ticks
    softFireW = 1'b0;
    if (!keyBad) begin
      nxt_st.softCntW = 8'h00;
    end else if (tick) begin
      if (st_ff.softCntW == 8'(wrc_pkg::WRC_SOFT_RESET_TICKS - 8'h01)) begin
        softFireW = 1'b1;
        nxt_st.softCntW = 8'h00;
      end else begin
        nxt_st.softCntW = 8'(st_ff.softCntW + 8'h01);
      end
    end

    // ************************************************************
    // supply key delay
    // ************************************************************
    // R12: bad supply key arms reset
    softFireL = 1'b0;
    if (!lvBad) begin
      nxt_st.softCntL = 8'h00;
    end else if (tick) begin
      if (st_ff.softCntL == 8'(wrc_pkg::WRC_SOFT_RESET_TICKS - 8'h01)) begin
        softFireL = 1'b1;
        nxt_st.softCntL = 8'h00;
      end else begin
        nxt_st.softCntL = 8'(st_ff.softCntL + 8'h01);
      end
    end

    // ************************************************************
    // monitor arming and bandgap
    // ************************************************************
    // R14: monitor off while halted
    nxt_st.lvActive = lvOn && !isHalted;
    // R16: bandgap on for bit or monitor
    nxt_st.bgPower = st_ff.bgEn | lvOn;

    // ************************************************************
    // low supply qualification
    // ************************************************************
    // R10: dip must outlast qualify time
    lvFire = 1'b0;
    if (!(lvOn && !isHalted && lowNow)) begin
      nxt_st.lvQualCnt = 8'h00;
    end else if (tick) begin
      if (st_ff.lvQualCnt == wrc_pkg::WRC_LV_QUALIFY_TICKS) begin
        lvFire = 1'b1;
        nxt_st.lvQualCnt = 8'h00;
      end else begin
        nxt_st.lvQualCnt = 8'(st_ff.lvQualCnt + 8'h01);
      end
    end

    // ************************************************************
    // apb slave, one wait state
    // ************************************************************
    access = apbReq.psel && apbReq.penable && st_ff.rsp.pready;
    wrEn = access && apbReq.pwrite;
    rd = wrcRead(apbReq.paddr, st_ff);
    nxt_st.rsp.pready = apbReq.psel && apbReq.penable && !st_ff.rsp.pready;
    nxt_st.rsp.pslverr = 1'b0;
    if (apbReq.psel && apbReq.penable && !st_ff.rsp.pready) begin
      nxt_st.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rd[31:0];
      nxt_st.rsp.pslverr = rd[32];
    end

    // ************************************************************
    // register writes
    // ************************************************************
    if (wrEn) begin
      case (apbReq.paddr)
        wrc_pkg::WRC_OFS_WDT_CTRL: nxt_st.wdtCtrl = apbReq.pwdata[7:0];
        wrc_pkg::WRC_OFS_CAUSE: nxt_st.cause = apbReq.pwdata[2:0];
        wrc_pkg::WRC_OFS_LV_CTRL: nxt_st.lvCtrl = apbReq.pwdata[7:0];
        wrc_pkg::WRC_OFS_BANDGAP: nxt_st.bgEn = apbReq.pwdata[wrc_pkg::WRC_BG_BIT];
        default: nxt_st.bgEn = nxt_st.bgEn;
      endcase
    end
    // R08: bad key written clears the count
    if (wrEn && (apbReq.paddr == wrc_pkg::WRC_OFS_WDT_CTRL)
        && wrcKeyBad(apbReq.pwdata[7:3])) begin
      nxt_st.wdtCnt = 15'h0000;
    end

    // ************************************************************
    // instructions and power state
    // ************************************************************
    // R08: clear instruction
    if (clearWatchdogInstr && st_ff.pwr == wrc_pkg::WRC_RUN) begin
      nxt_st.wdtCnt = 15'h0000;
      nxt_st.pdFlag = 1'b0;
      nxt_st.toFlag = 1'b0;
    end

    // ************************************************************
    // power state machine
    // ************************************************************
    nxt_st.devReset = 1'b0;
    nxt_st.wakeClear = 1'b0;
    nxt_st.porInit = 1'b0;
    anyFullReset = softFireW || softFireL || lvFire || (wdtOverflow && !isHalted);
    case (st_ff.pwr)
      wrc_pkg::WRC_RUN: begin
        // R22: halt entry
        if (haltInstr && !anyFullReset) begin
          nxt_st.pwr = wrc_pkg::WRC_HALTED;
          nxt_st.pdFlag = 1'b1;
          nxt_st.toFlag = 1'b0;
          nxt_st.wdtCnt = 15'h0000;
        end
      end
      wrc_pkg::WRC_HALTED: begin
        // R07: halted overflow wakes, clears pc and sp only
        if (wdtOverflow) begin
          nxt_st.pwr = wrc_pkg::WRC_RUN;
          nxt_st.wakeClear = 1'b1;
          // R21: timeout and power-down both high
          nxt_st.toFlag = 1'b1;
          nxt_st.pdFlag = 1'b1;
        end else if (wakeEvent) begin
          nxt_st.pwr = wrc_pkg::WRC_RUN;
        end
      end
      wrc_pkg::WRC_RSTOUT: begin
        nxt_st.pwr = wrc_pkg::WRC_RUN;
      end
      default: begin
        nxt_st.pwr = wrc_pkg::WRC_RUN;
      end
    endcase

    // ************************************************************
    // full device resets
    // ************************************************************
    if (anyFullReset) begin
      nxt_st.pwr = wrc_pkg::WRC_RSTOUT;
      nxt_st.devReset = 1'b1;
      nxt_st.wakeClear = 1'b1;
      nxt_st.wdtCnt = 15'h0000;
      nxt_st.softCntW = 8'h00;
      nxt_st.softCntL = 8'h00;
      nxt_st.lvQualCnt = 8'h00;
      // R04: control back to 0x53
      nxt_st.wdtCtrl = wrc_pkg::WRC_WDT_CTRL_RST;
      nxt_st.bgEn = 1'b0;
      // R12: bad supply key restores 0x5a
      if (!lvFire || softFireL) begin
        nxt_st.lvCtrl = wrc_pkg::WRC_LV_CTRL_RST;
      end
      // R13: genuine low supply keeps supply control
      if (lvFire && !softFireL) begin
        nxt_st.lvCtrl = st_ff.lvCtrl;
      end
    end

    // ************************************************************
    // status flags after a reset
    // ************************************************************
    // R06: running overflow sets timeout, keeps power-down
    if (wdtOverflow && !isHalted) begin
      nxt_st.toFlag = 1'b1;
    end
    // R21: low supply alone leaves both flags as they were
    if (lvFire && !wdtOverflow) begin
      nxt_st.toFlag = st_ff.toFlag;
      nxt_st.pdFlag = st_ff.pdFlag;
    end

    // ************************************************************
    // reset-cause flags
    // ************************************************************
    // set wins over a software clear in the same cycle
    // R09: watchdog key flag set
    if (softFireW) begin
      nxt_st.cause[wrc_pkg::WRC_WRF_BIT] = 1'b1;
    end
    // R18: supply key flag set
    if (softFireL) begin
      nxt_st.cause[wrc_pkg::WRC_LRF_BIT] = 1'b1;
    end
    // R17: low supply flag set
    if (lvFire) begin
      nxt_st.cause[wrc_pkg::WRC_LOW_SUPPLY_RESET_FLAG_BIT] = 1'b1;
    end

    // ************************************************************
    // registered status
    // ************************************************************
    nxt_st.haltQ = (nxt_st.pwr == wrc_pkg::WRC_HALTED);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk) begin
    // R15 R19: power-on values
    if (!rst_b) begin
      st_ff <= wrc_pkg::WRC_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign apbRsp = st_ff.rsp;
  assign deviceReset = st_ff.devReset;
  assign pcSpClear = st_ff.wakeClear;
  // R20: power-on init pulse to core and ports
  assign powerOnInit = st_ff.porInit;

  // ************************************************************
  // status outputs
  // ************************************************************
  assign timeoutFlag = st_ff.toFlag;
  assign powerDownFlag = st_ff.pdFlag;
  assign lowSupplyEnable = st_ff.lvActive;
  assign bandgapPower = st_ff.bgPower;
  assign halted = st_ff.haltQ;

endmodule

/* wrc_pkg.sv */
// watchdog and reset control: constants, types and register map
package wrc_pkg;

  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] WRC_OFS_WDT_CTRL = 8'h00;
  localparam logic [7:0] WRC_OFS_CAUSE = 8'h04;
  localparam logic [7:0] WRC_OFS_LV_CTRL = 8'h08;
  localparam logic [7:0] WRC_OFS_BANDGAP = 8'h0c;
  localparam logic [7:0] WRC_OFS_STATUS = 8'h10;

  // ************************************************************
  // field positions and codes
  // ************************************************************
  localparam int WRC_KEY_LSB = 3;
  localparam int WRC_BG_BIT = 3;
  localparam int WRC_WRF_BIT = 0;
  localparam int WRC_LRF_BIT = 1;
  localparam int WRC_LOW_SUPPLY_RESET_FLAG_BIT = 2;
  localparam logic [4:0] WRC_KEY_ENABLE = 5'h0a;
  localparam logic [4:0] WRC_KEY_DISABLE = 5'h15;
  localparam logic [7:0] WRC_LV_ENABLE = 8'h5a;
  localparam logic [7:0] WRC_LV_DISABLE = 8'ha5;
  localparam int WRC_MIN_DIV_LOG2 = 8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] WRC_WDT_CTRL_RST = 8'h53;
  localparam logic [7:0] WRC_LV_CTRL_RST = 8'h5a;

  // ************************************************************
  // counts of slow oscillator periods
  // ************************************************************
  localparam logic [7:0] WRC_SOFT_RESET_TICKS = 8'h04;
  localparam logic [7:0] WRC_LV_QUALIFY_TICKS = 8'h04;

  typedef enum logic [1:0] {
    WRC_RUN = 2'h0,
    WRC_HALTED = 2'h1,
    WRC_RSTOUT = 2'h3
  } wrc_pwr_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } wrc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wrc_apb_rsp_s;

  typedef struct packed {
    logic [7:0] wdtCtrl;
    logic [2:0] cause;
    logic [7:0] lvCtrl;
    logic bgEn;
    logic toFlag;
    logic pdFlag;
    logic [14:0] wdtCnt;
    logic [7:0] softCntW;
    logic [7:0] softCntL;
    logic [7:0] lvQualCnt;
    logic [2:0] oscSync;
    logic [2:0] lowSync;
    logic oscStable;
    logic lowStable;
    wrc_pwr_e pwr;
    logic devReset;
    logic wakeClear;
    logic porInit;
    logic lvActive;
    logic bgPower;
    logic haltQ;
    wrc_apb_rsp_s rsp;
  } wrc_state_s;

  localparam wrc_state_s WRC_STATE_RST = '{
    wdtCtrl: WRC_WDT_CTRL_RST, cause: 3'h0, lvCtrl: WRC_LV_CTRL_RST, bgEn: 1'b0,
    toFlag: 1'b0, pdFlag: 1'b0, wdtCnt: 15'h0000, softCntW: 8'h00, softCntL: 8'h00,
    lvQualCnt: 8'h00, oscSync: 3'h0, lowSync: 3'h0, oscStable: 1'b0, lowStable: 1'b0,
    pwr: WRC_RUN, devReset: 1'b0, wakeClear: 1'b0, porInit: 1'b1, lvActive: 1'b1,
    bgPower: 1'b1, haltQ: 1'b0, rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0}
  };

endpackage

/* wrc_core_model.sv */
// processor core stand-in: slow oscillator and instruction pulses
`timescale 1ns/1ps
module wrc_core_model (
  input wire logic mclk,
  input wire logic doClr,
  input wire logic doHalt,
  output logic slowOscClock,
  output logic clearWatchdogInstr = 1'b0,
  output logic haltInstr = 1'b0
);
  logic [2:0] divCnt = 3'h0;
  always @(posedge mclk) begin
    divCnt <= divCnt + 3'h1;
  end
  assign slowOscClock = divCnt[2];
  always @(posedge mclk) begin
    clearWatchdogInstr <= doClr;
    haltInstr <= doHalt;
  end
endmodule

/* wrc_watchdog_reset_monitor.sv */
// assertion checker for the watchdog and reset control block
`timescale 1ns/1ps
module wrc_watchdog_reset_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire wrc_pkg::wrc_apb_req_s apbReq,
  input wire wrc_pkg::wrc_apb_rsp_s apbRsp,
  input wire logic clearWatchdogInstr,
  input wire logic haltInstr,
  input wire logic deviceReset,
  input wire logic pcSpClear,
  input wire logic timeoutFlag,
  input wire logic powerDownFlag,
  input wire logic lowSupplyEnable,
  input wire logic bandgapPower,
  input wire logic halted
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_access;
    apbReq.psel && apbReq.penable;
  endsequence
  sequence s_halt_taken;
    haltInstr && !halted ##1 !deviceReset;
  endsequence
  sequence s_clr_taken;
    clearWatchdogInstr && !halted ##1 !deviceReset;
  endsequence
  property p_apb_wait;
    s_setup ##1 s_access |-> !apbRsp.pready ##1 apbRsp.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  property p_rdy_pulse;
    apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_err;
    apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_run_to;
    $rose(timeoutFlag) && !$past(halted) |-> deviceReset && pcSpClear && $stable(powerDownFlag);
  endproperty
  a_run_to: assert property (p_run_to) else $error("running timeout wrong");
  property p_halt_to;
    $rose(timeoutFlag) && $past(halted) |-> !deviceReset && pcSpClear && powerDownFlag && !halted;
  endproperty
  a_halt_to: assert property (p_halt_to) else $error("halted timeout wrong");
  property p_halt;
    s_halt_taken |-> halted && powerDownFlag && !timeoutFlag;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_clr;
    s_clr_taken |-> !timeoutFlag && !powerDownFlag;
  endproperty
  a_clr: assert property (p_clr) else $error("clear flags wrong");
  property p_lv_halt;
    halted && $past(halted) |-> !lowSupplyEnable;
  endproperty
  a_lv_halt: assert property (p_lv_halt) else $error("monitor armed while halted");
  property p_bg;
    lowSupplyEnable |-> bandgapPower;
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap off while monitor on");
  property p_rst_pc;
    deviceReset |-> pcSpClear;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("reset without pc clear");
endmodule
bind wrc_watchdog_reset wrc_watchdog_reset_monitor i_wrc_watchdog_reset_monitor (
  .mclk(mclk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
  .clearWatchdogInstr(clearWatchdogInstr), .haltInstr(haltInstr), .deviceReset(deviceReset),
  .pcSpClear(pcSpClear), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
  .lowSupplyEnable(lowSupplyEnable), .bandgapPower(bandgapPower), .halted(halted));

/* wrc_watchdog_reset_tb.sv */
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
module wrc_watchdog_reset_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  wrc_pkg::wrc_apb_req_s apbReq = '0;
  wrc_pkg::wrc_apb_rsp_s apbRsp;
  logic lowSupplyIn = 1'b0;
  logic doClr = 1'b0;
  logic doHalt = 1'b0;
  logic wakeEvent = 1'b0;
  logic slowOscClock, clearWatchdogInstr, haltInstr, deviceReset, pcSpClear, powerOnInit;
  logic timeoutFlag, powerDownFlag, lowSupplyEnable, bandgapPower, halted, err;
  logic [31:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int nRst = 0;
  int rises = 0;
  int rAt = 0;
  int k0;
  always #20 mclk = ~mclk;
  always @(posedge slowOscClock) rises++;
  always @(posedge mclk) begin
    if (deviceReset === 1'b1) begin
      nRst <= nRst + 1;
      rAt <= rises;
    end
  end
  wrc_core_model i_wrc_core_model (.mclk(mclk), .doClr(doClr), .doHalt(doHalt),
    .slowOscClock(slowOscClock), .clearWatchdogInstr(clearWatchdogInstr), .haltInstr(haltInstr));
  wrc_watchdog_reset i_wrc_watchdog_reset (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq),
    .apbRsp(apbRsp), .slowOscClock(slowOscClock), .lowSupplyIn(lowSupplyIn),
    .clearWatchdogInstr(clearWatchdogInstr), .haltInstr(haltInstr), .wakeEvent(wakeEvent),
    .deviceReset(deviceReset), .pcSpClear(pcSpClear), .powerOnInit(powerOnInit),
    .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
    .lowSupplyEnable(lowSupplyEnable), .bandgapPower(bandgapPower), .halted(halted));
  // ****
  // tasks
  // ****
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apbReq <= '{a, 1'b1, 1'b0, wr, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic waitRst(input int lim);
    int k;
    k = nRst;
    repeat (lim) if (nRst == k) @(posedge mclk);
    chk("resets", nRst, k + 1);
    repeat (4) @(posedge mclk);
  endtask
  // issue clear or halt just after a slow tick
  task automatic instr(input logic h);
    @(posedge slowOscClock);
    repeat (4) @(posedge mclk);
    doHalt <= h;
    doClr <= !h;
    @(posedge mclk);
    doHalt <= 1'b0;
    doClr <= 1'b0;
    rises = 0;
    repeat (3) @(posedge mclk);
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (8) @(posedge mclk);
    chk("powerOnInit", powerOnInit, 32'h1);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(wrc_pkg::WRC_OFS_WDT_CTRL, 32'h53);
    rd(wrc_pkg::WRC_OFS_CAUSE, 32'h0);
    rd(wrc_pkg::WRC_OFS_LV_CTRL, 32'h5a);
    rd(wrc_pkg::WRC_OFS_BANDGAP, 32'h0);
    chk("lv on", {lowSupplyEnable, bandgapPower, powerOnInit}, 32'h6);
    rd(8'h20, 32'h0);
    chk("pslverr", err, 32'h1);
    $display("test reset values done");
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, wrc_pkg::WRC_OFS_WDT_CTRL, {24'h0, wrc_pkg::WRC_KEY_ENABLE, s[2:0]});
      instr(1'b0);
      chk("clear flags", {timeoutFlag, powerDownFlag}, 32'h0);
      waitRst(20000);
      chk("ticks", rAt, 32'd256 << s);
      chk("timeoutFlag", timeoutFlag, 32'h1);
      rd(wrc_pkg::WRC_OFS_WDT_CTRL, 32'h53);
    end
    apb(1'b1, wrc_pkg::WRC_OFS_WDT_CTRL, {24'h0, wrc_pkg::WRC_KEY_DISABLE, 3'h0});
    k0 = nRst;
    repeat (2400) @(posedge mclk);
    chk("resets", nRst, k0);
    $display("test timeout done");
    apb(1'b1, wrc_pkg::WRC_OFS_WDT_CTRL, 32'hff);
    waitRst(200);
    rd(wrc_pkg::WRC_OFS_CAUSE, 32'h1);
    rd(wrc_pkg::WRC_OFS_WDT_CTRL, 32'h53);
    apb(1'b1, wrc_pkg::WRC_OFS_CAUSE, 32'h0);
    rd(wrc_pkg::WRC_OFS_CAUSE, 32'h0);
    apb(1'b1, wrc_pkg::WRC_OFS_LV_CTRL, 32'h33);
    waitRst(200);
    rd(wrc_pkg::WRC_OFS_CAUSE, 32'h2);
    rd(wrc_pkg::WRC_OFS_LV_CTRL, 32'h5a);
    apb(1'b1, wrc_pkg::WRC_OFS_CAUSE, 32'h0);
    $display("test key resets done");
    k0 = nRst;
    lowSupplyIn <= 1'b1;
    repeat (16) @(posedge mclk);
    lowSupplyIn <= 1'b0;
    repeat (80) @(posedge mclk);
    chk("resets", nRst, k0);
    lowSupplyIn <= 1'b1;
    waitRst(200);
    lowSupplyIn <= 1'b0;
    rd(wrc_pkg::WRC_OFS_CAUSE, 32'h4);
    rd(wrc_pkg::WRC_OFS_LV_CTRL, 32'h5a);
    apb(1'b1, wrc_pkg::WRC_OFS_LV_CTRL, 32'ha5);
    @(posedge mclk);
    chk("lv off", {lowSupplyEnable, bandgapPower}, 32'h0);
    apb(1'b1, wrc_pkg::WRC_OFS_BANDGAP, 32'h8);
    @(posedge mclk);
    chk("bandgapPower", bandgapPower, 32'h1);
    k0 = nRst;
    lowSupplyIn <= 1'b1;
    repeat (80) @(posedge mclk);
    lowSupplyIn <= 1'b0;
    chk("resets", nRst, k0);
    $display("test low supply done");
    apb(1'b1, wrc_pkg::WRC_OFS_LV_CTRL, 32'h5a);
    apb(1'b1, wrc_pkg::WRC_OFS_WDT_CTRL, {24'h0, wrc_pkg::WRC_KEY_ENABLE, 3'h0});
    instr(1'b1);
    chk("halt", {halted, powerDownFlag, timeoutFlag, lowSupplyEnable}, 32'hc);
    wakeEvent <= 1'b1;
    @(posedge mclk);
    wakeEvent <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("wake event", {halted, powerDownFlag, timeoutFlag}, 32'h2);
    instr(1'b1);
    k0 = nRst;
    repeat (4000) if (halted === 1'b1) @(posedge mclk);
    chk("wake", {halted, powerDownFlag, timeoutFlag}, 32'h3);
    chk("resets", nRst, k0);
    rd(wrc_pkg::WRC_OFS_STATUS, 32'h3);
    $display("test halt done");
    end_of_test;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end
endmodule
